// >>> uart_gate_defs.svh
// Constants for the transmit gate and multidrop control block.
// Assumes inclusion by the package and the design modules.
`ifndef UART_GATE_DEFS_SVH
`define UART_GATE_DEFS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_TRANSMIT_PERMIT    32'h40008030
`define ADDR_MULTIDROP_CONTROL  32'h4000804C
`define ADDR_ADDRESS_MATCH      32'h40008050
`define ADDR_RELEASE_DELAY      32'h40008054
`define ADDR_FRACTIONAL         32'h40008028

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define BIT_TRANSMIT_PERMIT     7
`define BIT_MULTIDROP_ENABLE    0
`define BIT_RECEIVER_DISABLE    1
`define BIT_AUTO_ADDRESS        2
`define BIT_DIRECTION_SELECT    3
`define BIT_AUTO_DIRECTION      4
`define BIT_DIRECTION_INVERT    5
`define MULTIDROP_WIDTH         6
`define RESET_TRANSMIT_PERMIT   1'h1
`define RESET_MULTIDROP         6'h00
`define RESET_ADDRESS_MATCH     8'h00
`define RESET_RELEASE_DELAY     8'h00
`define RESET_FRACTIONAL        8'h10

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLOCK_MHZ               20
`define BITS_PER_CHAR           10
`define BAUD_OVERSAMPLE         16

`endif

// >>> uart_gate_pkg.sv
// Types shared by the transmit gate and multidrop control block.
// Assumes the defs header is on the include path.
package uart_gate_pkg;
`include "uart_gate_defs.svh"

    typedef struct packed {
        logic        direction_polarity_invert;
        logic        auto_direction_enable;
        logic        direction_select;
        logic        auto_address_detect_enable;
        logic        receiver_disable;
        logic        multidrop_enable;
    } multidrop_ctrl_t;

    typedef struct packed {
        logic        valid;
        logic        ninth;
        logic [7:0]  data;
    } rx_char_t;

    typedef struct packed {
        logic        write;
        logic        read;
        logic [31:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

endpackage

// >>> uart_char_shifter.sv
// Transmit shift register timing: one character per start, one bit per baud tick.
// Assumes a single-cycle baud tick from the block's own divider.
`timescale 1ns/1ps
`include "uart_gate_defs.svh"

module uart_char_shifter
    import uart_gate_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    // Control
    input  wire logic       i_baud_tick,
    input  wire logic       i_start,
    input  wire logic [7:0] i_data,
    // Status
    output logic            o_busy,
    output logic            o_done,
    output logic            o_txd
);
    import uart_gate_pkg::*;

    logic [9:0] frame;
    logic [3:0] bits_left;
    logic [7:0] held;
    logic       waiting;

    // Frame loads on the next tick so the start bit lasts a full bit period
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            frame     <= 10'h3FF;
            bits_left <= 4'h0;
            held      <= 8'h00;
            waiting   <= 1'b0;
            o_busy    <= 1'b0;
            o_done    <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start && !o_busy) begin
                held    <= i_data;
                waiting <= 1'b1;
                o_busy  <= 1'b1;
            end else if (o_busy && i_baud_tick && waiting) begin
                frame     <= {1'b1, held, 1'b0};
                bits_left <= 4'(`BITS_PER_CHAR);
                waiting   <= 1'b0;
            end else if (o_busy && i_baud_tick) begin
                frame <= {1'b1, frame[9:1]};
                bits_left <= bits_left - 4'h1;
                if (bits_left == 4'h1) begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                end
            end
        end
    end

    assign o_txd = frame[0];

endmodule

// >>> uart_release_timer.sv
// Counts baud periods between the last stop bit and direction release.
// Assumes a single-cycle baud tick.
`timescale 1ns/1ps

module uart_release_timer
    import uart_gate_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    // Control
    input  wire logic       i_baud_tick,
    input  wire logic       i_load,
    input  wire logic [7:0] i_delay,
    // Status
    output logic            o_running
);
    import uart_gate_pkg::*;

    logic [7:0] count;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count     <= 8'h00;
            o_running <= 1'b0;
        end else if (i_load) begin
            count     <= i_delay;
            o_running <= (i_delay != 8'h00);
        end else if (o_running && i_baud_tick) begin
            count <= count - 8'h01;
            if (count == 8'h01) begin
                o_running <= 1'b0;
            end
        end
    end

endmodule

// >>> uart_tx_gate_rs485_control.sv
// Transmit gating, multidrop receive filter and direction control of a UART.
// Assumes register port, holding buffer, baud tick and receive path share one clock; no pin inputs.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "uart_gate_defs.svh"

// Function
// R1 - Permit bit resets set; characters flow freely
// R2 - Clearing permit finishes current character, then stops
// R3 - Software toggles permit for flow control
// R4 - Bit 0 flags ninth-bit bytes as addresses
// R5 - Bit 1 disables receiver, resets zero; code ignores it unless bit 0 is set
// R6 - Bit 2 enables auto address, resets zero
// R7 - Bit 3 selects RTS or DTR pin
// R8 - Bit 4 enables auto direction, resets zero
// R9 - Polarity clear: low while pending, then high
// R10 - Polarity set: high while pending, then low
// R11 - Software picks fraction only within ratio bounds
// R12 - Auto address match stores, mismatch disables
// R13 - Direction release delayed by programmed baud periods
// R14 - Disabled receiver drops data, keeps addresses
// R15 - Control bits read back; reserved bits ignored
module uart_tx_gate_rs485_control
    import uart_gate_pkg::*;
(
    // Clock and reset
    input  wire logic                      i_clock,
    input  wire logic                      i_rst_n,
    // Register port
    input  wire uart_gate_pkg::reg_req_t   i_req,
    output logic [31:0]                    o_rdata,
    // Transmit holding buffer side
    input  wire logic                      i_thr_valid,
    input  wire logic [7:0]                i_thr_data,
    output logic                           o_thr_pop,
    // Baud tick from divider
    input  wire logic                      i_baud_tick,
    // Received characters from the shift register
    input  wire uart_gate_pkg::rx_char_t   i_rx,
    output uart_gate_pkg::rx_char_t        o_rx_push,
    output logic                           o_rx_ready_irq,
    output logic                           o_parity_irq,
    // Serial and direction pins
    output logic                           o_txd,
    output logic                           o_rts_n,
    output logic                           o_dtr_n
);
    import uart_gate_pkg::*;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic            transmit_permit_bit;
    multidrop_ctrl_t ctrl;
    logic [7:0]      address_match_value;
    logic [7:0]      direction_release_delay;
    logic [7:0]      fractional_ratio;
    logic            next_receiver_disable;
    logic            hw_set_disable;
    logic            hw_clr_disable;

    function automatic logic hit(input logic [31:0] a, input logic [31:0] ref_addr);
        return a == ref_addr;
    endfunction

    // Permit bit: software only
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            transmit_permit_bit <= `RESET_TRANSMIT_PERMIT; // see R1
        end else if (i_req.write && hit(i_req.addr, `ADDR_TRANSMIT_PERMIT)) begin
            transmit_permit_bit <= i_req.wdata[`BIT_TRANSMIT_PERMIT]; // see R3
        end
    end

    // Receiver disable: hardware update wins over a software write in the same cycle
    always_comb begin
        next_receiver_disable = ctrl.receiver_disable;
        if (i_req.write && hit(i_req.addr, `ADDR_MULTIDROP_CONTROL)) begin
            next_receiver_disable = i_req.wdata[`BIT_RECEIVER_DISABLE];
        end
        if (hw_set_disable) begin
            next_receiver_disable = 1'b1; // see R12
        end else if (hw_clr_disable) begin
            next_receiver_disable = 1'b0; // see R12
        end
    end

    // Whole word first, then the hardware-aware receiver disable bit
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl <= multidrop_ctrl_t'(`RESET_MULTIDROP); // see R5 R6 R8
        end else begin
            if (i_req.write && hit(i_req.addr, `ADDR_MULTIDROP_CONTROL)) begin
                ctrl <= multidrop_ctrl_t'(i_req.wdata[`MULTIDROP_WIDTH-1:0]); // see R15
            end
            ctrl.receiver_disable <= next_receiver_disable;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            address_match_value     <= `RESET_ADDRESS_MATCH;
            direction_release_delay <= `RESET_RELEASE_DELAY;
            fractional_ratio        <= `RESET_FRACTIONAL;
        end else if (i_req.write) begin
            if (hit(i_req.addr, `ADDR_ADDRESS_MATCH)) begin
                address_match_value <= i_req.wdata[7:0];
            end
            if (hit(i_req.addr, `ADDR_RELEASE_DELAY)) begin
                direction_release_delay <= i_req.wdata[7:0];
            end
            if (hit(i_req.addr, `ADDR_FRACTIONAL)) begin
                fractional_ratio <= i_req.wdata[7:0]; // see R11
            end
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 32'h00000000;
        end else if (i_req.read) begin
            o_rdata <= 32'h00000000;
            if (hit(i_req.addr, `ADDR_TRANSMIT_PERMIT)) begin
                o_rdata[`BIT_TRANSMIT_PERMIT] <= transmit_permit_bit; // see R15
            end else if (hit(i_req.addr, `ADDR_MULTIDROP_CONTROL)) begin
                o_rdata[`MULTIDROP_WIDTH-1:0] <= ctrl; // see R15
            end else if (hit(i_req.addr, `ADDR_ADDRESS_MATCH)) begin
                o_rdata[7:0] <= address_match_value;
            end else if (hit(i_req.addr, `ADDR_RELEASE_DELAY)) begin
                o_rdata[7:0] <= direction_release_delay;
            end else if (hit(i_req.addr, `ADDR_FRACTIONAL)) begin
                o_rdata[7:0] <= fractional_ratio;
            end
        end
    end

    // ----------------------------------------
    // Transmit gate
    // ----------------------------------------
    logic shifter_busy;
    logic shifter_done;
    logic shifter_txd;
    logic start_char;

    // Gate only the hand-off; a character already shifting always completes
    assign start_char = i_thr_valid && transmit_permit_bit && !shifter_busy && !o_thr_pop; // see R1 R2

    // Pop trails the start by one cycle; the guard stops a stale head restarting
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_thr_pop <= 1'b0;
        end else begin
            o_thr_pop <= start_char;
        end
    end

    uart_char_shifter u_shifter (
        .i_clock     (i_clock),
        .i_rst_n     (i_rst_n),
        .i_baud_tick (i_baud_tick),
        .i_start     (start_char),
        .i_data      (i_thr_data),
        .o_busy      (shifter_busy),
        .o_done      (shifter_done),
        .o_txd       (shifter_txd)
    );

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_txd <= 1'b1;
        end else begin
            o_txd <= shifter_txd;
        end
    end

    // ----------------------------------------
    // Direction control
    // ----------------------------------------
    logic delay_running;
    logic pending;
    logic dir_level;

    // Timer reloads on every done, so each character restarts the count
    uart_release_timer u_release (
        .i_clock     (i_clock),
        .i_rst_n     (i_rst_n),
        .i_baud_tick (i_baud_tick),
        .i_load      (shifter_done),
        .i_delay     (direction_release_delay),
        .o_running   (delay_running)
    );

    // Pending covers queued data, the shifting character and the release delay
    assign pending   = i_thr_valid || shifter_busy || shifter_done || delay_running; // see R13
    assign dir_level = pending ^ !ctrl.direction_polarity_invert; // see R9 R10

    // Unselected pin parks high so no stray driver enable reaches the line
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rts_n <= 1'b1;
            o_dtr_n <= 1'b1;
        end else begin
            o_rts_n <= 1'b1;
            o_dtr_n <= 1'b1;
            if (ctrl.auto_direction_enable) begin // see R8
                if (ctrl.direction_select) begin // see R7
                    o_dtr_n <= dir_level;
                end else begin
                    o_rts_n <= dir_level;
                end
            end
        end
    end

    // ----------------------------------------
    // Multidrop receive filter
    // ----------------------------------------
    logic is_address;
    logic matched;
    logic accept;

    assign is_address = ctrl.multidrop_enable && i_rx.ninth; // see R4
    assign matched    = i_rx.data == address_match_value;
    assign hw_set_disable = i_rx.valid && is_address && ctrl.auto_address_detect_enable && !matched; // see R12
    assign hw_clr_disable = i_rx.valid && is_address && ctrl.auto_address_detect_enable && matched; // see R12

    // Outside multidrop mode every character is kept
    always_comb begin
        accept = 1'b1;
        if (ctrl.multidrop_enable) begin
            if (ctrl.auto_address_detect_enable) begin
                accept = is_address ? matched : !ctrl.receiver_disable; // see R6 R12
            end else if (ctrl.receiver_disable) begin
                accept = is_address; // see R14
            end
        end
    end

    // Parity flag only for address bytes that are stored
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rx_push      <= '0;
            o_rx_ready_irq <= 1'b0;
            o_parity_irq   <= 1'b0;
        end else begin
            o_rx_push      <= '{valid: i_rx.valid && accept, ninth: i_rx.ninth, data: i_rx.data};
            o_rx_ready_irq <= i_rx.valid && accept; // see R14
            o_parity_irq   <= i_rx.valid && is_address && accept; // see R4
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    gate_blocks_start_a: assert property (!transmit_permit_bit |=> !o_thr_pop) // see R2
        else $error("character popped while permit clear");

    busy_finishes_a: assert property (shifter_busy && !transmit_permit_bit && i_baud_tick |=> shifter_busy || shifter_done) // see R2
        else $error("character aborted");

    pop_follows_start_a: assert property (start_char |=> o_thr_pop && shifter_busy) // see R1
        else $error("start without pop");

    line_idle_a: assert property (!shifter_busy |=> o_txd) // see R1
        else $error("serial line not idle high");

    rts_polarity_a: assert property (ctrl.auto_direction_enable && !ctrl.direction_select && !ctrl.direction_polarity_invert && shifter_busy |=> !o_rts_n) // see R9
        else $error("rts not low while sending");

    dtr_inverted_a: assert property (ctrl.auto_direction_enable && ctrl.direction_select && ctrl.direction_polarity_invert && shifter_busy |=> o_dtr_n) // see R10
        else $error("dtr not high while sending");

    dtr_selected_a: assert property (ctrl.auto_direction_enable && ctrl.direction_select |=> o_rts_n) // see R7
        else $error("rts driven while dtr selected");

    unselected_idle_a: assert property (!ctrl.auto_direction_enable |=> o_rts_n && o_dtr_n) // see R8
        else $error("direction pin driven while disabled");

    mismatch_disables_a: assert property (hw_set_disable |=> ctrl.receiver_disable && !o_rx_push.valid) // see R12
        else $error("mismatch not discarded");

    match_enables_a: assert property (hw_clr_disable |=> !ctrl.receiver_disable && o_rx_push.valid && o_rx_ready_irq) // see R12
        else $error("matching address not stored");

    data_dropped_a: assert property (i_rx.valid && ctrl.multidrop_enable && ctrl.receiver_disable && !i_rx.ninth |=> !o_rx_push.valid) // see R14
        else $error("data kept while disabled");

    address_kept_a: assert property (i_rx.valid && is_address && !ctrl.auto_address_detect_enable |=> o_rx_push.valid && o_parity_irq) // see R4
        else $error("address not stored");

    release_held_a: assert property (shifter_done && direction_release_delay != 8'h00 |=> delay_running) // see R13
        else $error("release delay skipped");

    delay_zero_a: assert property (shifter_done && direction_release_delay == 8'h00 |=> !delay_running) // see R13
        else $error("zero delay still running");

    // Main scenarios
    cover_char_sent: cover property (start_char ##[1:300] shifter_done);
    cover_match: cover property (hw_clr_disable);
    cover_delay: cover property (shifter_done ##1 delay_running);
    cover_permit_hold: cover property (!transmit_permit_bit && i_thr_valid && !shifter_busy);
endmodule

// >>> uart_far_node.sv
// Far-side model: transmit holding buffer, baud tick source and serial line listener.
// Assumes one clock shared with the gate block; ticks every eight clocks.
`timescale 1ns/1ps

module uart_far_node (
    // Clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    // Buffer loading and popping
    input  wire logic       i_load,
    input  wire logic [7:0] i_load_data,
    input  wire logic       i_pop,
    output logic            o_thr_valid,
    output logic [7:0]      o_thr_data,
    // Baud tick and serial line
    output logic            o_baud_tick,
    input  wire logic       i_txd,
    output logic            o_byte_valid,
    output logic [7:0]      o_byte
);
    logic [7:0] q[$];
    logic [2:0] phase;
    logic [7:0] shreg;
    logic [3:0] nbits;
    logic       prev_txd;
    logic       armed;
    logic       active;

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q.delete();
            o_thr_valid <= 1'b0;
            o_thr_data  <= 8'h00;
            phase       <= 3'h0;
            o_baud_tick <= 1'b0;
            prev_txd    <= 1'b1;
            armed       <= 1'b0;
            active      <= 1'b0;
            nbits       <= 4'h0;
            o_byte_valid <= 1'b0;
        end else begin
            if (i_pop && q.size() != 0) void'(q.pop_front());
            if (i_load) q.push_back(i_load_data);
            o_thr_valid <= (q.size() != 0);
            // Empty buffer inverts the data every cycle, so the old head returns every other cycle
            o_thr_data  <= (q.size() != 0) ? q[0] : ~o_thr_data;
            phase       <= phase + 3'h1;
            o_baud_tick <= (phase == 3'h6);
            prev_txd    <= i_txd;
            o_byte_valid <= 1'b0;
            if (!active && !armed && prev_txd && !i_txd) armed <= 1'b1;
            if (armed && o_baud_tick) begin
                armed  <= 1'b0;
                active <= 1'b1;
                nbits  <= 4'h0;
            end
            // Mid-bit sampling, least significant bit first
            if (active && phase == 3'h4) begin
                shreg <= {i_txd, shreg[7:1]};
                nbits <= nbits + 4'h1;
                if (nbits == 4'h7) begin
                    active       <= 1'b0;
                    o_byte_valid <= 1'b1;
                    o_byte       <= {i_txd, shreg[7:1]};
                end
            end
        end
    end
endmodule

// >>> uart_tx_gate_rs485_control_tb.sv
// Self-checking bench for the transmit gate and multidrop control block.
// Assumes the far-side model and the defs header are on the compile path.
`timescale 1ns/1ps
`include "uart_gate_defs.svh"

module uart_tx_gate_rs485_control_tb;
    import uart_gate_pkg::*;
    logic            i_clock;
    logic            i_rst_n;
    reg_req_t        req;
    rx_char_t        rx;
    rx_char_t        rx_push;
    logic [31:0]     rdata;
    logic            thr_valid, thr_pop, baud_tick, ready_irq, par_irq, txd, rts_n, dtr_n;
    logic [7:0]      thr_data;
    logic            load, byte_valid;
    logic [7:0]      load_data, rx_byte;
    logic [7:0]      got_q[$];
    int              mismatches, n_checks, n_pops, cycles, base, pops0;

    uart_tx_gate_rs485_control DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_req(req), .o_rdata(rdata),
        .i_thr_valid(thr_valid), .i_thr_data(thr_data), .o_thr_pop(thr_pop), .i_baud_tick(baud_tick),
        .i_rx(rx), .o_rx_push(rx_push), .o_rx_ready_irq(ready_irq), .o_parity_irq(par_irq),
        .o_txd(txd), .o_rts_n(rts_n), .o_dtr_n(dtr_n));
    uart_far_node far (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_load(load), .i_load_data(load_data),
        .i_pop(thr_pop), .o_thr_valid(thr_valid), .o_thr_data(thr_data), .o_baud_tick(baud_tick),
        .i_txd(txd), .o_byte_valid(byte_valid), .o_byte(rx_byte));

    // ----------------------------------------
    // Clock, monitors and timeout
    // ----------------------------------------
    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        if (byte_valid === 1'b1) got_q.push_back(rx_byte);
        if (thr_pop === 1'b1) n_pops++;
        cycles++;
        // Whole run needs well under five thousand cycles
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_write(input logic [31:0] a, input logic [31:0] d);
        @(posedge i_clock);
        req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
        @(posedge i_clock);
        req <= '0;
    endtask
    task automatic read_check(input logic [31:0] a, input logic [31:0] exp);
        @(posedge i_clock);
        req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 32'h0};
        @(posedge i_clock);
        req <= '0;
        #1;
        check(rdata, exp);
    endtask
    task automatic send(input logic [7:0] b);
        @(posedge i_clock);
        load      <= 1'b1;
        load_data <= b;
        @(posedge i_clock);
        load      <= 1'b0;
    endtask
    task automatic wait_bytes(input int n);
        for (int i = 0; i < 600 && got_q.size() < n; i++) @(posedge i_clock);
    endtask
    task automatic wait_pops(input int n);
        for (int i = 0; i < 300 && n_pops < n; i++) @(posedge i_clock);
    endtask
    task automatic rx_send(input logic n, input logic [7:0] d, input logic exp_push, input logic exp_par);
        @(posedge i_clock);
        rx <= '{valid: 1'b1, ninth: n, data: d};
        @(posedge i_clock);
        rx <= '0;
        #1;
        check({rx_push.valid, ready_irq, par_irq}, {exp_push, exp_push, exp_par});
        if (exp_push) check({rx_push.ninth, rx_push.data}, {n, d});
    endtask
    task automatic dir_case(input logic sel, input logic inv, input logic held);
        reg_write(`ADDR_MULTIDROP_CONTROL, 32'h10 | (32'(sel) << 3) | (32'(inv) << 5));
        base = got_q.size();
        send(8'h5A);
        repeat (6) @(posedge i_clock);
        #1;
        check({sel ? dtr_n : rts_n, sel ? rts_n : dtr_n}, {inv, 1'b1});
        wait_bytes(base + 1);
        repeat (24) @(posedge i_clock);
        #1;
        check({sel ? dtr_n : rts_n, sel ? rts_n : dtr_n}, {held ? inv : ~inv, 1'b1});
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        i_rst_n = 1'b0;
        req = '0;
        rx = '0;
        load = 1'b0;
        load_data = 8'h00;
        repeat (12) @(posedge i_clock);
        i_rst_n <= 1'b1;
        read_check(`ADDR_TRANSMIT_PERMIT, 32'h80);
        read_check(`ADDR_MULTIDROP_CONTROL, 32'h0);
        read_check(`ADDR_ADDRESS_MATCH, 32'h0);
        read_check(`ADDR_RELEASE_DELAY, 32'h0);
        read_check(`ADDR_FRACTIONAL, 32'h10);
        reg_write(`ADDR_MULTIDROP_CONTROL, 32'hFFFFFFFF);
        read_check(`ADDR_MULTIDROP_CONTROL, 32'h3F);
        reg_write(`ADDR_MULTIDROP_CONTROL, 32'h0);
        read_check(`ADDR_MULTIDROP_CONTROL, 32'h0);
        reg_write(`ADDR_TRANSMIT_PERMIT, 32'hFFFFFFFF);
        read_check(`ADDR_TRANSMIT_PERMIT, 32'h80);
        reg_write(`ADDR_FRACTIONAL, 32'h85);
        read_check(`ADDR_FRACTIONAL, 32'h85);
        reg_write(32'h40008000, 32'hFFFFFFFF);
        read_check(32'h40008000, 32'h0);
        $display("test registers done");

        // Back-to-back characters, direction control off
        base = got_q.size();
        send(8'hA5);
        send(8'h3C);
        repeat (6) @(posedge i_clock);
        #1;
        check({rts_n, dtr_n}, 2'b11);
        wait_bytes(base + 2);
        check(got_q.size(), base + 2);
        check(got_q[base], 8'hA5);
        check(got_q[base + 1], 8'h3C);
        $display("test transmit done");

        // Permit cleared while a character is on the line
        base = got_q.size();
        pops0 = n_pops;
        send(8'h11);
        send(8'h22);
        wait_pops(pops0 + 1);
        reg_write(`ADDR_TRANSMIT_PERMIT, 32'h0);
        repeat (300) @(posedge i_clock);
        check(got_q.size(), base + 1);
        check(got_q[base], 8'h11);
        check(n_pops, pops0 + 1);
        check(thr_valid, 1'b1);
        reg_write(`ADDR_TRANSMIT_PERMIT, 32'h80);
        wait_bytes(base + 2);
        check(got_q[base + 1], 8'h22);
        $display("test permit done");

        // Direction pin selection and polarity
        for (int k = 0; k < 4; k++) dir_case(k[0], k[1], 1'b0);
        reg_write(`ADDR_RELEASE_DELAY, 32'h05);
        dir_case(1'b0, 1'b1, 1'b1);
        repeat (56) @(posedge i_clock);
        #1;
        check(rts_n, 1'b0);
        reg_write(`ADDR_RELEASE_DELAY, 32'h0);
        $display("test direction done");

        // Receive filtering
        reg_write(`ADDR_ADDRESS_MATCH, 32'h42);
        rx_send(1'b0, 8'h10, 1'b1, 1'b0);
        reg_write(`ADDR_MULTIDROP_CONTROL, 32'h01);
        rx_send(1'b0, 8'h11, 1'b1, 1'b0);
        rx_send(1'b1, 8'h12, 1'b1, 1'b1);
        reg_write(`ADDR_MULTIDROP_CONTROL, 32'h03);
        rx_send(1'b0, 8'h13, 1'b0, 1'b0);
        rx_send(1'b1, 8'h14, 1'b1, 1'b1);
        reg_write(`ADDR_MULTIDROP_CONTROL, 32'h07);
        rx_send(1'b0, 8'h15, 1'b0, 1'b0);
        rx_send(1'b1, 8'h41, 1'b0, 1'b0);
        read_check(`ADDR_MULTIDROP_CONTROL, 32'h07);
        rx_send(1'b1, 8'h42, 1'b1, 1'b1);
        read_check(`ADDR_MULTIDROP_CONTROL, 32'h05);
        rx_send(1'b0, 8'h16, 1'b1, 1'b0);
        rx_send(1'b1, 8'h43, 1'b0, 1'b0);
        read_check(`ADDR_MULTIDROP_CONTROL, 32'h07);
        $display("test receive done");
        final_report();
    end
endmodule
